// [hdl/gbc_pkg.sv]
/*
  Shared constants and carrier types of the gate bias calculation control.
  Assumes a single 250 MHz device clock and byte addresses on the bus.
*/
package gbc_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [5:0] OFF_STAGED_CH1  = 6'h00;
  localparam logic [5:0] OFF_STAGED_CH2  = 6'h04;
  localparam logic [5:0] OFF_DIRECT_CH1  = 6'h08;
  localparam logic [5:0] OFF_DIRECT_CH2  = 6'h0c;
  localparam logic [5:0] OFF_LOAD_DAC    = 6'h10;
  localparam logic [5:0] OFF_CAL_CONTROL = 6'h14;
  localparam logic [5:0] OFF_CONV_SELECT = 6'h18;
  localparam logic [5:0] OFF_SW_CONFIG   = 6'h1c;
  localparam logic [5:0] OFF_HYSTERESIS  = 6'h20;
  localparam logic [5:0] OFF_SETPOINT1   = 6'h24;
  localparam logic [5:0] OFF_SETPOINT2   = 6'h28;
  localparam logic [5:0] OFF_PARAM1      = 6'h2c;
  localparam logic [5:0] OFF_PARAM2      = 6'h30;
  localparam logic [5:0] OFF_STATUS      = 6'h34;
  localparam logic [5:0] OFF_OUT_CH1     = 6'h38;
  localparam logic [5:0] OFF_OUT_CH2     = 6'h3c;
  // ==========================================================
  // Field positions
  localparam int CAL_TRACK_BIT  = 0;
  localparam int CAL_START_BIT  = 1;
  localparam int CAL_PERIOD_BIT = 2;
  localparam int CONV_CONT_BIT  = 7;
  localparam int SW_CH_STRIDE   = 6;
  localparam int SW_TSRC_POS    = 2;
  localparam int SW_PARAM_EN    = 3;
  localparam int SW_TEMP_EN     = 4;
  localparam int SW_LOAD_POS    = 5;
  localparam int SW_LIMIT_POS   = 12;
  localparam int SW_EQ_BIT      = 15;
  localparam int HYS_TEMP_POS   = 4;
  localparam int HYS_TABLE_POINT_SIZE_POS  = 12;
  // ==========================================================
  // Reset values and timing
  localparam logic [15:0] SW_CONFIG_RST = 16'h0000;
  localparam logic [15:0] HYST_RST      = 16'h0000;
  localparam logic [2:0]  CAL_RST       = 3'h0;
  localparam int CLK_MHZ        = 250;
  localparam int CAL_PERIOD_MS  = 13;
  localparam int CAL_PERIOD_CYC = CAL_PERIOD_MS * CLK_MHZ * 1000;
  localparam int CAL_STEP_CYC   = 16;
  // ==========================================================
  // Types
  typedef enum logic [1:0] {SRC_STORED, SRC_RESERVED, SRC_CURRENT, SRC_AUX}
    gbc_src_t;
  typedef enum {CAL_IDLE, CAL_CH1, CAL_CH2, CAL_WAIT} gbc_cal_t;
  typedef struct packed {
    logic        valid;
    logic [11:0] data;
  } gbc_sample_t;
endpackage

// [hdl/gbc_control.sv]
/*
  Gate bias calculation control: averaging, trigger gating, DAC staging,
  amplifier calibration scheduling and conversion channel selection.
  Assumes samples and results arrive from logic on ref_clk and that the
  register bus is an Avalon-MM master on the same clock.
*/
// Implementation choices: the register addresses and the Avalon-MM slave port.
// Contract
// R1: Ch2 average moves by 1/16 of difference at 0, 1/4 at 1.
// R2: Ch2 limiter code 0 no limit, codes 1..7 limit to 1..127 LSBs.
// R3: Source 00 stored, 10 current, 11 aux; software never picks 01.
// R4: New parameter sample triggers calculation only beyond shared hysteresis.
// R5: Software clears both compensation enables before changing hysteresis.
// R6: Staged write keeps 12 bits; output changes only on load.
// R7: Staged write starts no calculation.
// R8: Direct write loads staged and output, no calculation.
// R9: DAC staged and output values are never saved.
// R10: Calibration control is saved; upper bits ignored.
// R11: Track bit 0 acquisition mode, 1 tracking mode calibration.
// R12: Software keeps track bit 0 for first calibration after power-up.
// R13: Start bit calibrates both amplifiers and self-clears when done.
// R14: Powered-down channel calibration is skipped, other still runs.
// R15: Periodic bit with start bit repeats calibration about every 13 ms.
// R16: Without periodic bit each start write runs one calibration.
// R17: Setpoint write always starts a calculation.
// R18: Temperature change beyond hysteresis triggers when enabled.
// R19: Stored source: parameter write triggers when compensation enabled.
// R20: Sampled source triggers when a new table entry is selected.
// R21: Seven select bits, continuous bit, upper bits ignored.
// R22: Conversion write starts the next selected channel in sequence.
// R23: Ch2 equation choice applies only in tracking mode.
// R24: Load bit 1 results to staged only, 0 to both.
// R25: Difference clamped to plus or minus limit before update.
`timescale 1ns/1ps
module gbc_control #(
  parameter int CAL_PERIOD = gbc_pkg::CAL_PERIOD_CYC,
  parameter int CAL_STEP   = gbc_pkg::CAL_STEP_CYC
) (
  input  wire logic                ref_clk,
  input  wire logic                reset_n,
  input  wire logic [5:0]          address,
  input  wire logic                read,
  input  wire logic                write,
  input  wire logic [31:0]         writedata,
  output logic      [31:0]         readdata,
  output logic                     waitrequest,
  input  gbc_pkg::gbc_sample_t     tempExt [2],
  input  gbc_pkg::gbc_sample_t     tempInt,
  input  gbc_pkg::gbc_sample_t     currentSample [2],
  input  gbc_pkg::gbc_sample_t     auxSample [2],
  input  gbc_pkg::gbc_sample_t     gateResult [2],
  input  wire logic                trackingMode,
  input  wire logic [1:0]          chPowerDown,
  input  wire logic                adcWriteStarts,
  input  wire logic                convDone,
  output logic      [1:0]          calcStart,
  output logic      [11:0]         gateSetpoint [2],
  output logic      [11:0]         paramValue [2],
  output logic      [11:0]         gateOut [2],
  output logic      [1:0]          calStart,
  output logic                     calTrackMode,
  output logic      [2:0]          calNvImage,
  output logic                     convStart,
  output logic      [2:0]          convChannel
);
  // ==========================================================
  // Bus slave: one wait cycle, request taken when ackReg is high
  logic        ackReg;
  logic [31:0] readdataReg;
  wire         busReq  = read | write;
  wire         busTake = busReq & ackReg;
  wire         wrTake  = write & ackReg;
  wire  [15:0] wd      = writedata[15:0];
  wire         wrStaged1 = wrTake & (address == gbc_pkg::OFF_STAGED_CH1);
  wire         wrStaged2 = wrTake & (address == gbc_pkg::OFF_STAGED_CH2);
  wire         wrDirect1 = wrTake & (address == gbc_pkg::OFF_DIRECT_CH1);
  wire         wrDirect2 = wrTake & (address == gbc_pkg::OFF_DIRECT_CH2);
  wire         wrLoad    = wrTake & (address == gbc_pkg::OFF_LOAD_DAC);
  wire         wrCal     = wrTake & (address == gbc_pkg::OFF_CAL_CONTROL);
  wire         wrConv    = wrTake & (address == gbc_pkg::OFF_CONV_SELECT);
  wire         wrSw      = wrTake & (address == gbc_pkg::OFF_SW_CONFIG);
  wire         wrHyst    = wrTake & (address == gbc_pkg::OFF_HYSTERESIS);
  wire         wrSet1    = wrTake & (address == gbc_pkg::OFF_SETPOINT1);
  wire         wrSet2    = wrTake & (address == gbc_pkg::OFF_SETPOINT2);
  wire         wrPar1    = wrTake & (address == gbc_pkg::OFF_PARAM1);
  wire         wrPar2    = wrTake & (address == gbc_pkg::OFF_PARAM2);
  wire  [1:0]  wrStaged  = {wrStaged2, wrStaged1};
  wire  [1:0]  wrDirect  = {wrDirect2, wrDirect1};
  wire  [1:0]  wrSet     = {wrSet2, wrSet1};
  wire  [1:0]  wrPar     = {wrPar2, wrPar1};

  assign waitrequest = busReq & ~ackReg;
  assign readdata    = readdataReg;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ackReg <= 1'b0;
    end else begin
      ackReg <= busReq & ~ackReg;
    end
  end

  // ==========================================================
  // Configuration registers
  logic [15:0] swReg;
  logic [15:0] hystReg;
  logic [2:0]  calReg;
  logic [6:0]  convSelReg;
  logic        convContReg;
  logic        calDone;
  gbc_pkg::gbc_cal_t calState;
  wire  [3:0]  paramHyst = hystReg[3:0];
  wire  [7:0]  tempHyst  = hystReg[gbc_pkg::HYS_TEMP_POS +: 8];
  wire  [2:0]  pointSize = hystReg[gbc_pkg::HYS_TABLE_POINT_SIZE_POS +: 3];
  wire  [2:0]  limitCode = swReg[gbc_pkg::SW_LIMIT_POS +: 3];
  wire         eqQuarter = swReg[gbc_pkg::SW_EQ_BIT] & trackingMode; // R23
  wire         calBusy   = (calState != gbc_pkg::CAL_IDLE);

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      swReg       <= gbc_pkg::SW_CONFIG_RST;
      hystReg     <= gbc_pkg::HYST_RST;
      convSelReg  <= 7'h00;
      convContReg <= 1'b0;
    end else begin
      if (wrSw) swReg <= wd;
      // Software must hold both enables low while this changes
      if (wrHyst) hystReg <= wd; // R5
      if (wrConv) begin
        convSelReg  <= wd[6:0]; // R21
        convContReg <= wd[gbc_pkg::CONV_CONT_BIT];
      end
    end
  end

  // Start bit: a new write wins over self-clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      calReg <= gbc_pkg::CAL_RST;
    end else if (wrCal) begin
      calReg <= wd[2:0]; // R10
    end else if (calDone) begin
      calReg[gbc_pkg::CAL_START_BIT] <= 1'b0; // R13
    end
  end
  assign calNvImage   = calReg; // R10
  assign calTrackMode = calReg[gbc_pkg::CAL_TRACK_BIT]; // R11

  // ==========================================================
  // Calibration sequencer
  logic [31:0] calCnt;
  logic [1:0]  calStartReg;
  wire         startBit  = calReg[gbc_pkg::CAL_START_BIT];
  wire         periodic  = calReg[gbc_pkg::CAL_PERIOD_BIT];
  wire         cntZero   = (calCnt == 32'h0);
  wire         runCh1    = ~chPowerDown[0]; // R14
  wire         runCh2    = ~chPowerDown[1]; // R14
  wire  [31:0] stepLoad  = 32'(CAL_STEP - 1);
  wire  [31:0] perLoad   = 32'(CAL_PERIOD - 1);
  assign calStart = calStartReg;
  assign calDone  = (calState == gbc_pkg::CAL_CH2) & cntZero & ~periodic;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      calState    <= gbc_pkg::CAL_IDLE;
      calCnt      <= 32'h0;
      calStartReg <= 2'b00;
    end else begin
      calStartReg <= 2'b00;
      if (!cntZero) calCnt <= calCnt - 32'h1;
      unique case (calState)
        gbc_pkg::CAL_IDLE: begin
          if (startBit && !wrCal) begin // R16
            calState       <= gbc_pkg::CAL_CH1;
            calCnt         <= stepLoad;
            calStartReg[0] <= runCh1; // R13
          end
        end
        gbc_pkg::CAL_CH1: begin
          if (cntZero) begin
            calState       <= gbc_pkg::CAL_CH2;
            calCnt         <= stepLoad;
            calStartReg[1] <= runCh2; // R13
          end
        end
        gbc_pkg::CAL_CH2: begin
          if (cntZero) begin
            calState <= periodic ? gbc_pkg::CAL_WAIT : gbc_pkg::CAL_IDLE;
            calCnt   <= periodic ? perLoad : 32'h0; // R15
          end
        end
        gbc_pkg::CAL_WAIT: begin
          // Clearing the start bit ends the periodic runs
          if (!startBit || !periodic) begin
            calState <= gbc_pkg::CAL_IDLE;
            calCnt   <= 32'h0;
          end else if (cntZero) begin
            calState       <= gbc_pkg::CAL_CH1;
            calCnt         <= stepLoad;
            calStartReg[0] <= runCh1; // R15
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Conversion channel sequencing
  logic [2:0] convChReg;
  logic       convStartReg;
  logic       convPend;
  function automatic logic [2:0] nextSel(input logic [2:0] cur,
                                         input logic [6:0] sel);
    logic [2:0] idx;
    logic       hit;
    nextSel = cur;
    hit     = 1'b0;
    for (int i = 1; i <= 7; i++) begin
      idx = 3'((32'(cur) + i) % 7);
      if (!hit && sel[idx]) begin
        nextSel = idx;
        hit     = 1'b1;
      end
    end
  endfunction
  wire       convGo  = (convPend | (convDone & convContReg)) &
                       (convSelReg != 7'h00);
  assign convStart   = convStartReg;
  assign convChannel = convChReg;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      convChReg    <= 3'h6;
      convStartReg <= 1'b0;
    end else begin
      convStartReg <= 1'b0;
      if (convGo) begin
        convChReg    <= nextSel(convChReg, convSelReg); // R22
        convStartReg <= 1'b1;
      end
    end
  end
  // Write-triggered start uses the new select word one cycle later
  always_ff @(posedge ref_clk) begin
    if (!reset_n) convPend <= 1'b0;
    else convPend <= wrConv & adcWriteStarts & (wd[6:0] != 7'h00);
  end

  // ==========================================================
  // Per-channel averaging, triggers and DAC registers
  logic [1:0]  trigNow;
  logic [12:0] tempAvg [2];
  function automatic logic [11:0] absDiff(input logic [11:0] a,
                                          input logic [11:0] b);
    absDiff = (a > b) ? (a - b) : (b - a);
  endfunction

  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    localparam int B = ch * gbc_pkg::SW_CH_STRIDE;
    gbc_pkg::gbc_src_t src;
    logic [11:0] stagedReg;
    logic [11:0] outReg;
    logic [11:0] tempUsed;
    logic [11:0] paramUsed;
    logic        calcReg;
    assign src = gbc_pkg::gbc_src_t'(swReg[B +: 2]);
    wire  tSel   = swReg[B + gbc_pkg::SW_TSRC_POS];
    wire  pEn    = swReg[B + gbc_pkg::SW_PARAM_EN];
    wire  tEn    = swReg[B + gbc_pkg::SW_TEMP_EN];
    wire  loadLo = swReg[B + gbc_pkg::SW_LOAD_POS];
    gbc_pkg::gbc_sample_t tS;
    gbc_pkg::gbc_sample_t pS;
    assign tS = tSel ? tempInt : tempExt[ch];
    assign pS = (src == gbc_pkg::SRC_AUX) ? auxSample[ch]
                                          : currentSample[ch]; // R3
    // Signed difference, clamped on channel 2 only
    wire signed [13:0] diff = $signed({2'b00, tS.data}) -
                              $signed({1'b0, tempAvg[ch]});
    wire signed [13:0] lim  = $signed(14'((1 << limitCode) - 1)); // R2
    wire        doClamp = (ch == 1) && (limitCode != 3'h0);
    wire signed [13:0] dClamp = !doClamp ? diff :
                                (diff > lim) ? lim :
                                (diff < -lim) ? -lim : diff; // R25
    wire signed [13:0] step = (ch == 1 && eqQuarter) ? (dClamp >>> 2)
                                                     : (dClamp >>> 4); // R1
    wire [12:0] avgNext = 13'($signed({1'b0, tempAvg[ch]}) + step);
    wire tempTrig  = tEn & tS.valid &
                     (absDiff(avgNext[11:0], tempUsed) > 12'(tempHyst)); // R18
    wire storedTrig = pEn & (src == gbc_pkg::SRC_STORED) & wrPar[ch]; // R19
    wire sampTrig  = pEn & src[1] & pS.valid &
                     (absDiff(pS.data, paramUsed) > 12'(paramHyst)) & // R4
                     ((pS.data >> pointSize) != (paramUsed >> pointSize)); // R20
    // Staged and direct writes are deliberately absent here
    assign trigNow[ch] = wrSet[ch] | tempTrig | storedTrig | sampTrig; // R17
    assign calcStart[ch] = calcReg;
    assign gateOut[ch]   = outReg;

    always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
        calcReg          <= 1'b0;
        tempAvg[ch]      <= 13'h0;
        tempUsed         <= 12'h0;
        paramUsed        <= 12'h0;
        gateSetpoint[ch] <= 12'h0;
        paramValue[ch]   <= 12'h0;
      end else begin
        calcReg <= trigNow[ch]; // R7
        if (tS.valid) tempAvg[ch] <= avgNext;
        if (tempTrig) tempUsed <= avgNext[11:0];
        if (sampTrig) paramUsed <= pS.data;
        if (wrSet[ch]) gateSetpoint[ch] <= wd[11:0];
        if (wrPar[ch]) paramValue[ch] <= wd[11:0];
      end
    end

    // Not saved anywhere: DAC values are lost at power-down
    always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
        stagedReg <= 12'h0; // R9
        outReg    <= 12'h0;
      end else if (wrDirect[ch]) begin
        stagedReg <= wd[11:0]; // R8
        outReg    <= wd[11:0];
      end else if (wrStaged[ch]) begin
        stagedReg <= wd[11:0]; // R6
      end else if (wrLoad && wd[ch]) begin
        outReg <= stagedReg; // R6
      end else if (gateResult[ch].valid) begin
        stagedReg <= gateResult[ch].data;
        if (!loadLo) outReg <= gateResult[ch].data; // R24
      end
    end
  end

  // ==========================================================
  // Read data: write-only registers and holes read as zero
  wire [31:0] statusWord = {27'h0, calBusy, periodic, startBit,
                            calTrackMode, convContReg};
  wire [31:0] rdMux = (address == gbc_pkg::OFF_STATUS) ? statusWord :
                      (address == gbc_pkg::OFF_OUT_CH1) ?
                        {20'h0, g_ch[0].outReg} :
                      (address == gbc_pkg::OFF_OUT_CH2) ?
                        {20'h0, g_ch[1].outReg} : 32'h0;
  always_ff @(posedge ref_clk) begin
    if (!reset_n) readdataReg <= 32'h0;
    else if (read && !ackReg) readdataReg <= rdMux;
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  localparam int CAL_MAX = 64;

  property p_staged_hold;
    wrStaged1 && !gateResult[0].valid |=> $stable(g_ch[0].outReg);
  endproperty
  a_staged_hold: assert property (p_staged_hold) // R6
    else $error("staged write changed output");

  property p_direct_load;
    logic [11:0] v;
    (wrDirect2, v = wd[11:0]) |=> gateOut[1] == v && g_ch[1].stagedReg == v;
  endproperty
  a_direct_load: assert property (p_direct_load) // R8
    else $error("direct write did not load both registers");

  property p_no_calc;
    (wrStaged1 | wrDirect1) && !g_ch[0].tempTrig && !g_ch[0].sampTrig
      |=> !calcStart[0];
  endproperty
  a_no_calc: assert property (p_no_calc) // R7
    else $error("DAC write started a calculation");

  property p_setpoint;
    wrSet1 |=> calcStart[0];
  endproperty
  a_setpoint: assert property (p_setpoint) // R17
    else $error("setpoint write missed calculation");

  sequence s_manual_begin;
    calState == gbc_pkg::CAL_IDLE && startBit && !periodic && !wrCal;
  endsequence
  property p_self_clear;
    s_manual_begin ##1 (!wrCal)[*1] |-> ##[1:CAL_MAX] !startBit;
  endproperty
  a_self_clear: assert property (p_self_clear) // R13
    else $error("start bit never cleared");

  property p_periodic_keep;
    calState == gbc_pkg::CAL_CH2 && cntZero && periodic && !wrCal
      |=> startBit && calState == gbc_pkg::CAL_WAIT;
  endproperty
  a_periodic_keep: assert property (p_periodic_keep) // R15
    else $error("periodic calibration not rescheduled");

  property p_skip_down;
    calStart[1] |-> !$past(chPowerDown[1]);
  endproperty
  a_skip_down: assert property (p_skip_down) // R14
    else $error("powered-down channel calibrated");

  property p_conv_sel;
    convStart |-> convSelReg[convChannel];
  endproperty
  a_conv_sel: assert property (p_conv_sel) // R21
    else $error("unselected channel converted");

  property p_load_ctl;
    gateResult[1].valid && g_ch[1].loadLo && !wrDirect2 && !wrStaged2 &&
      !(wrLoad && wd[1]) |=> $stable(gateOut[1]);
  endproperty
  a_load_ctl: assert property (p_load_ctl) // R24
    else $error("result reached output with load bit set");
endmodule

// [verification/tb_gbc_control.sv]
/*
  Self-checking bench for the gate bias calculation control block.
  Assumes the block's register map and one-wait bus timing,
  shortened calibration counts, and a 250 MHz ref_clk.
*/
`timescale 1ns/1ps
module tb_gbc_control;
  localparam int CAL_PERIOD = 200;
  localparam int CAL_STEP   = 4;
  logic                 ref_clk;
  logic                 reset_n;
  logic [5:0]           address;
  logic                 read;
  logic                 write;
  logic [31:0]          writedata;
  logic [31:0]          readdata;
  logic                 waitrequest;
  gbc_pkg::gbc_sample_t tempExt [2];
  gbc_pkg::gbc_sample_t tempInt;
  gbc_pkg::gbc_sample_t currentSample [2];
  gbc_pkg::gbc_sample_t auxSample [2];
  gbc_pkg::gbc_sample_t gateResult [2];
  logic                 trackingMode;
  logic [1:0]           chPowerDown;
  logic                 adcWriteStarts;
  logic                 convDone;
  logic [1:0]           calcStart;
  logic [11:0]          gateSetpoint [2];
  logic [11:0]          paramValue [2];
  logic [11:0]          gateOut [2];
  logic [1:0]           calStart;
  logic                 calTrackMode;
  logic [2:0]           calNvImage;
  logic                 convStart;
  logic [2:0]           convChannel;
  int                   n_errors;
  int                   cmp_count;
  int                   calcCnt;
  int                   cal0Cnt;
  int                   cal1Cnt;
  int                   convCnt;
  logic [31:0]          rd;
  // ==========================================================
  // Table rows: offset, data, expected gate outputs
  typedef struct {logic [5:0] a; logic [15:0] d; logic [11:0] g0, g1;}
    gbc_row_t;
  gbc_row_t rows [6] = '{
    '{gbc_pkg::OFF_STAGED_CH1, 16'hf123, 12'h000, 12'h000},
    '{gbc_pkg::OFF_DIRECT_CH2, 16'ha456, 12'h000, 12'h456},
    '{gbc_pkg::OFF_LOAD_DAC,   16'h0001, 12'h123, 12'h456},
    '{gbc_pkg::OFF_STAGED_CH2, 16'h0789, 12'h123, 12'h456},
    '{gbc_pkg::OFF_LOAD_DAC,   16'h0002, 12'h123, 12'h789},
    '{gbc_pkg::OFF_DIRECT_CH1, 16'hfabc, 12'habc, 12'h789}};

  gbc_control #(.CAL_PERIOD(CAL_PERIOD), .CAL_STEP(CAL_STEP)) DUT (
    .ref_clk(ref_clk), .reset_n(reset_n), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .tempExt(tempExt),
    .tempInt(tempInt), .currentSample(currentSample),
    .auxSample(auxSample), .gateResult(gateResult),
    .trackingMode(trackingMode), .chPowerDown(chPowerDown),
    .adcWriteStarts(adcWriteStarts), .convDone(convDone),
    .calcStart(calcStart), .gateSetpoint(gateSetpoint),
    .paramValue(paramValue), .gateOut(gateOut), .calStart(calStart),
    .calTrackMode(calTrackMode), .calNvImage(calNvImage),
    .convStart(convStart), .convChannel(convChannel));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Pulses are counted, not sampled once, so a stray one is never missed
  always @(posedge ref_clk) begin
    if (reset_n === 1'b1) begin
      calcCnt <= calcCnt + $countones(calcStart);
      cal0Cnt <= cal0Cnt + $countones(calStart[0]);
      cal1Cnt <= cal1Cnt + $countones(calStart[1]);
      convCnt <= convCnt + $countones(convStart);
    end
  end
  // ==========================================================
  // Helpers
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic bus(input logic wr, input logic [5:0] a,
                     input logic [15:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    address <= a;
    writedata <= {16'h0000, d};
    write <= wr;
    read <= ~wr;
    do begin
      @(posedge ref_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50) chk("waitrequest", 32'h1, 32'h0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic samp(input logic t, input logic [11:0] d);
    @(posedge ref_clk);
    currentSample[0] <= '{!t, d};
    tempExt[1] <= '{t, d};
    @(posedge ref_clk);
    currentSample[0] <= '0;
    tempExt[1] <= '0;
    repeat (4) @(posedge ref_clk);
  endtask

  task automatic conclude();
    $display("comparisons %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #20000;
    n_errors++;
    conclude();
  end
  // ==========================================================
  // Main sequence
  initial begin
    {read, write, address, writedata} = '0;
    tempExt = '{default: '0};
    tempInt = '0;
    currentSample = '{default: '0};
    auxSample = '{default: '0};
    gateResult = '{default: '0};
    {trackingMode, chPowerDown, adcWriteStarts, convDone} = '0;
    {n_errors, cmp_count, calcCnt, cal0Cnt, cal1Cnt, convCnt} = '0;
    reset_n = 1'b0;
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    #1;
    chk("convChannel", 32'(convChannel), 32'h6);
    chk("gateOut0", 32'(gateOut[0]), 32'h0);
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].d);
      @(posedge ref_clk);
      #1;
      chk("gateOut0", 32'(gateOut[0]), 32'(rows[i].g0));
      chk("gateOut1", 32'(gateOut[1]), 32'(rows[i].g1));
    end
    repeat (3) @(posedge ref_clk);
    chk("calcCnt", calcCnt, 0);
    bus(1'b1, gbc_pkg::OFF_HYSTERESIS, 16'h0002);
    bus(1'b1, gbc_pkg::OFF_SETPOINT1, 16'h0100);
    bus(1'b1, gbc_pkg::OFF_PARAM1, 16'h0010);
    repeat (3) @(posedge ref_clk);
    chk("calcCnt", calcCnt, 1);
    chk("setpoint0", 32'(gateSetpoint[0]), 32'h100);
    bus(1'b1, gbc_pkg::OFF_SW_CONFIG, 16'h0008);
    bus(1'b1, gbc_pkg::OFF_PARAM1, 16'h0020);
    repeat (3) @(posedge ref_clk);
    chk("calcCnt", calcCnt, 2);
    chk("param0", 32'(paramValue[0]), 32'h020);
    // Source 10: first sample moves far, second within hysteresis
    bus(1'b1, gbc_pkg::OFF_SW_CONFIG, 16'h000a);
    samp(1'b0, 12'h064);
    samp(1'b0, 12'h065);
    samp(1'b0, 12'h06e);
    chk("calcCnt", calcCnt, 4);
    // Enables drop before the hysteresis word may change
    bus(1'b1, gbc_pkg::OFF_SW_CONFIG, 16'h0000);
    bus(1'b1, gbc_pkg::OFF_HYSTERESIS, 16'h00f2);
    // Ch2 limit 127: step 7 stays under 15, unclamped 16 would not
    bus(1'b1, gbc_pkg::OFF_SW_CONFIG, 16'h7c00);
    samp(1'b1, 12'h100);
    chk("calcCnt", calcCnt, 4);
    trackingMode <= 1'b1;
    bus(1'b1, gbc_pkg::OFF_SW_CONFIG, 16'hfc00);
    samp(1'b1, 12'h100);
    chk("calcCnt", calcCnt, 5);
    @(posedge ref_clk);
    gateResult <= '{default: '{1'b1, 12'h321}};
    @(posedge ref_clk);
    gateResult <= '{default: '0};
    @(posedge ref_clk);
    chk("gateOut0", 32'(gateOut[0]), 32'h321);
    chk("gateOut1", 32'(gateOut[1]), 32'h789);
    bus(1'b1, gbc_pkg::OFF_LOAD_DAC, 16'h0002);
    @(posedge ref_clk);
    chk("gateOut1", 32'(gateOut[1]), 32'h321);
    // Upper bits set on purpose; only three low bits survive
    bus(1'b1, gbc_pkg::OFF_CAL_CONTROL, 16'h7ff2);
    repeat (3) @(posedge ref_clk);
    chk("calNvImage", 32'(calNvImage), 32'h2);
    chk("calTrackMode", 32'(calTrackMode), 32'h0);
    repeat (4 * CAL_STEP) @(posedge ref_clk);
    chk("cal0Cnt", cal0Cnt, 1);
    chk("cal1Cnt", cal1Cnt, 1);
    bus(1'b0, gbc_pkg::OFF_STATUS, 16'h0000);
    chk("startBit", 32'(rd[2]), 32'h0);
    chPowerDown <= 2'b10;
    bus(1'b1, gbc_pkg::OFF_CAL_CONTROL, 16'h0002);
    repeat (5 * CAL_STEP) @(posedge ref_clk);
    chk("cal0Cnt", cal0Cnt, 2);
    chk("cal1Cnt", cal1Cnt, 1);
    chPowerDown <= 2'b00;
    bus(1'b1, gbc_pkg::OFF_CAL_CONTROL, 16'h0007);
    repeat (CAL_PERIOD + 12 * CAL_STEP) @(posedge ref_clk);
    chk("cal1Cnt", cal1Cnt, 3);
    chk("calTrackMode", 32'(calTrackMode), 32'h1);
    bus(1'b0, gbc_pkg::OFF_STATUS, 16'h0000);
    chk("periodicStart", 32'(rd[3:2]), 32'h3);
    bus(1'b1, gbc_pkg::OFF_CAL_CONTROL, 16'h0000);
    adcWriteStarts <= 1'b1;
    bus(1'b1, gbc_pkg::OFF_CONV_SELECT, 16'h0005);
    bus(1'b1, gbc_pkg::OFF_CONV_SELECT, 16'hff85);
    bus(1'b0, gbc_pkg::OFF_STATUS, 16'h0000);
    chk("continuous", 32'(rd[0]), 32'h1);
    chk("convChannel", 32'(convChannel), 32'h2);
    convDone <= 1'b1;
    @(posedge ref_clk);
    convDone <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("convChannel", 32'(convChannel), 32'h0);
    chk("convCnt", convCnt, 3);
    bus(1'b0, gbc_pkg::OFF_STAGED_CH1, 16'h0000);
    chk("woRead", rd, 32'h0);
    bus(1'b0, 6'h02, 16'h0000);
    chk("unmapped", rd, 32'h0);
    conclude();
  end
endmodule
